// *** ext_pin_irq.sv ***
// Chosen here: the address map and the plain strobed port.
`include "ext_pin_irq_cfg.svh"
`default_nettype none

// Behaviour
// - pin activity raises enabled interrupts even when the pin drives as output
// - enabled low-level input requests continuously while the pin stays low, except in power-down and start-up
// - high-group edges need the i/o clock; low levels and low-group edges do not
// - power-down level wake samples the low level twice on watchdog ticks
// - level gone before start-up ends: wake anyway, but raise no request
// - low-group sense: 00 low, 01 reserved, 10 falling, 11 rising edge
// - high-group sense: 00 low, 01 any change, 10 falling, 11 rising
// - high-group pins sampled per clock; pulses over one period caught while the i/o clock runs
// - request reaches processor only with global enable and mask bit set
// - mask register: bit n enables input n, read/write, resets to zero
// - edge or change sets pending flag; cleared by acknowledge or writing one
// - pending flag held cleared while its input is in low-level mode
// - sleep with low-group input disabled turns its buffer off; may set flags
// - low-group sense reset value zero selects low-level mode
module ext_pin_irq
    import ext_pin_irq_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // register port
    input wire logic [1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // interrupt pins (pad level, including own output drive)
    input wire logic [7:0] EXT_IRQ_PINS,
    // processor side
    input wire logic GIE,
    input wire logic ACK_VALID,
    input wire logic [2:0] ACK_NUM,
    output logic [7:0] IRQ_REQ,
    output logic IRQ,
    // power state
    input wire logic IO_CLK_RUN,
    input wire logic SLEEP,
    input wire logic POWER_DOWN,
    output logic WAKE
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    localparam int unsigned WDT_CYCLES = `EXT_WDT_CYCLES;
    localparam int unsigned STARTUP_CYCLES = `EXT_STARTUP_CYCLES;

    function automatic logic [7:0] level_mode(input logic [7:0] lo, input logic [7:0] hi);
        logic [7:0] m;
        m = 8'h00;
        for (int n = 0; n < 4; n++) begin
            m[n] = (sense_t'(lo[2*n +: 2]) == SENSE_LOW);
            m[n+4] = (sense_t'(hi[2*n +: 2]) == SENSE_LOW);
        end
        return m;
    endfunction

    function automatic logic [7:0] onehot8(input logic [2:0] idx);
        return 8'h01 << idx;
    endfunction

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] low_sense_q;
    logic [7:0] high_sense_q;
    logic [7:0] mask_q;
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic [7:0] rdata_q;
    logic [7:0] irq_req_q;
    logic irq_q;
    logic wake_q;
    logic wake_d;

    logic [7:0] lvl_mode;
    logic [3:0] buf_en;
    logic [7:0] pin_eff;
    logic [3:0] hit_lo;
    logic [3:0] hit_hi;
    logic [7:0] hit;
    logic [7:0] clr;
    logic [7:0] lvl_low;
    logic [7:0] lvl_req;
    logic lvl_gate;
    logic any_lvl_low;

    wake_t wk_q;
    wake_t wk_d;
    logic [6:0] wdt_cnt_q;
    logic wdt_tick;
    logic [10:0] start_cnt_q;
    logic start_done;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            low_sense_q <= `EXT_RST_LOW_SENSE;
        end else if (WR && ADDR == `EXT_ADDR_LOW_SENSE) begin
            low_sense_q <= WDATA;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            high_sense_q <= `EXT_RST_HIGH_SENSE;
        end else if (WR && ADDR == `EXT_ADDR_HIGH_SENSE) begin
            high_sense_q <= WDATA;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            mask_q <= `EXT_RST_MASK;
        end else if (WR && ADDR == `EXT_ADDR_MASK) begin
            mask_q <= WDATA;
        end
    end

    // every address is mapped; read data stand for one cycle only
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rdata_q <= 8'h00;
        end else if (RD) begin
            unique case (ADDR)
                `EXT_ADDR_LOW_SENSE: rdata_q <= low_sense_q;
                `EXT_ADDR_HIGH_SENSE: rdata_q <= high_sense_q;
                `EXT_ADDR_MASK: rdata_q <= mask_q;
                `EXT_ADDR_FLAGS: rdata_q <= flags_q;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // ----------------------------------------
    // pin conditioning and detection
    // ----------------------------------------
    // a disabled low-group buffer reads as zero while asleep, which can look like a falling edge
    assign buf_en = ~({4{SLEEP}} & ~mask_q[3:0]);
    assign pin_eff = {EXT_IRQ_PINS[7:4], EXT_IRQ_PINS[3:0] & buf_en};
    assign lvl_mode = level_mode(low_sense_q, high_sense_q);

    lo_group_det u_lo (
        .clk(CLK),
        .resetn(RESETN),
        .pin_i(pin_eff[3:0]),
        .sense_i(low_sense_q),
        .hit_o(hit_lo)
    );

    hi_group_det u_hi (
        .clk(CLK),
        .resetn(RESETN),
        .sample_en(IO_CLK_RUN),
        .pin_i(pin_eff[7:4]),
        .sense_i(high_sense_q),
        .hit_o(hit_hi)
    );

    assign hit = {hit_hi, hit_lo};

    // ----------------------------------------
    // pending flags
    // ----------------------------------------
    // set beats clear so an edge in the clearing cycle is kept
    assign clr = ((WR && ADDR == `EXT_ADDR_FLAGS) ? WDATA : 8'h00)
               | (ACK_VALID ? onehot8(ACK_NUM) : 8'h00);
    assign flags_d = ((flags_q & ~clr) | hit) & ~lvl_mode;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            flags_q <= `EXT_RST_FLAGS;
        end else begin
            flags_q <= flags_d;
        end
    end

    // ----------------------------------------
    // watchdog tick divider
    // ----------------------------------------
    assign wdt_tick = (wdt_cnt_q == 7'(WDT_CYCLES - 1));

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            wdt_cnt_q <= 7'h00;
        end else if (wdt_tick) begin
            wdt_cnt_q <= 7'h00;
        end else begin
            wdt_cnt_q <= wdt_cnt_q + 7'h01;
        end
    end

    // ----------------------------------------
    // power-down level wake
    // ----------------------------------------
    assign lvl_low = lvl_mode & ~pin_eff & mask_q;
    assign any_lvl_low = |lvl_low;
    assign start_done = (start_cnt_q == 11'(STARTUP_CYCLES - 1));

    always_comb begin
        wk_d = wk_q;
        unique case (wk_q)
            WK_RUN: begin
                if (POWER_DOWN && wdt_tick && any_lvl_low) begin
                    wk_d = WK_SAMPLE;
                end
            end
            WK_SAMPLE: begin
                if (wdt_tick) begin
                    wk_d = any_lvl_low ? WK_START : WK_RUN;
                end
            end
            WK_START: begin
                if (start_done) begin
                    wk_d = WK_RUN;
                end
            end
            default: wk_d = WK_RUN;
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            wk_q <= WK_RUN;
        end else begin
            wk_q <= wk_d;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            start_cnt_q <= 11'h000;
        end else if (wk_q == WK_START && !start_done) begin
            start_cnt_q <= start_cnt_q + 11'h001;
        end else begin
            start_cnt_q <= 11'h000;
        end
    end

    // wake holds until the sleep controller drops power-down
    assign wake_d = POWER_DOWN && (wake_q
                  || (wk_q == WK_SAMPLE && wdt_tick && any_lvl_low)
                  || |(flags_q & mask_q & `EXT_LOW_GROUP_BITS));

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= wake_d;
        end
    end

    // ----------------------------------------
    // requests to the processor
    // ----------------------------------------
    // level requests stay off until start-up ends; a level gone by then is lost
    assign lvl_gate = (wk_q == WK_RUN) && !POWER_DOWN;
    assign lvl_req = lvl_gate ? lvl_low : 8'h00;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            irq_req_q <= 8'h00;
            irq_q <= 1'b0;
        end else begin
            irq_req_q <= GIE ? ((flags_q & mask_q) | lvl_req) : 8'h00;
            irq_q <= GIE && |((flags_q & mask_q) | lvl_req);
        end
    end

    assign RDATA = rdata_q;
    assign IRQ_REQ = irq_req_q;
    assign IRQ = irq_q;
    assign WAKE = wake_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    a_level_clears_flag: assert property (
        lvl_mode[0] |=> !flags_q[0]
    ) else $error("pending flag set in level mode");

    a_set_beats_clear: assert property (
        hit[5] && !lvl_mode[5] |=> flags_q[5]
    ) else $error("edge lost while clearing");

    a_w1c_clears: assert property (
        WR && ADDR == `EXT_ADDR_FLAGS && WDATA[2] && !hit[2] |=> !flags_q[2]
    ) else $error("write one did not clear flag");

    a_gate_global: assert property (
        !$past(GIE) |-> IRQ_REQ == 8'h00 && !IRQ
    ) else $error("request without global enable");

    a_level_holds: assert property (
        GIE && lvl_gate && lvl_mode[0] && mask_q[0] && !EXT_IRQ_PINS[0] |=> IRQ_REQ[0]
    ) else $error("low level not requested");

    a_mask_write: assert property (
        WR && ADDR == `EXT_ADDR_MASK |=> mask_q == $past(WDATA)
    ) else $error("mask write lost");

    a_reserved_quiet: assert property (
        sense_t'(low_sense_q[3:2]) == SENSE_ANY |-> !hit[1]
    ) else $error("reserved encoding raised event");

    a_hi_needs_clock: assert property (
        !IO_CLK_RUN |-> hit[7:4] == 4'h0
    ) else $error("high-group edge without i/o clock");

    a_two_samples: assert property (
        $rose(wk_q == WK_START) |-> $past(wk_q == WK_SAMPLE) && $past(any_lvl_low)
    ) else $error("start-up entered without second sample");

    a_no_req_in_start: assert property (
        wk_q == WK_START |=> (IRQ_REQ & lvl_mode & ~flags_q) == 8'h00
    ) else $error("level request during start-up");

    a_rise_sets: assert property (
        IO_CLK_RUN [*3] ##0 sense_t'(high_sense_q[3:2]) == SENSE_RISE && $rose(u_hi.cur_q[1])
        |=> flags_q[5]
    ) else $error("sampled rise missed");

    // an acknowledge without a new event in the same cycle must leave the flag clear
    a_ack_clears: assert property (
        ACK_VALID && ACK_NUM == 3'h1 && !hit[1] |=> !flags_q[1]
    ) else $error("acknowledge did not clear flag");

    a_wake_needs_pd: assert property (
        !POWER_DOWN |=> !WAKE
    ) else $error("wake outside power-down");

    a_irq_any: assert property (
        IRQ == (IRQ_REQ != 8'h00)
    ) else $error("summary request disagrees with per-input requests");

endmodule

`default_nettype wire

// *** ext_pin_irq_cfg.svh ***
`ifndef EXT_PIN_IRQ_CFG_SVH
`define EXT_PIN_IRQ_CFG_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define EXT_ADDR_LOW_SENSE 2'h0
`define EXT_ADDR_HIGH_SENSE 2'h1
`define EXT_ADDR_MASK 2'h2
`define EXT_ADDR_FLAGS 2'h3

// ----------------------------------------
// reset values and field layout
// ----------------------------------------
`define EXT_RST_LOW_SENSE 8'h00
`define EXT_RST_HIGH_SENSE 8'h00
`define EXT_RST_MASK 8'h00
`define EXT_RST_FLAGS 8'h00
`define EXT_SENSE_FIELD_W 2
`define EXT_LOW_GROUP_BITS 8'h0F

// ----------------------------------------
// timing
// ----------------------------------------
`define EXT_CLK_PERIOD_NS 10
`define EXT_WDT_PERIOD_NS 1000
`define EXT_WDT_CYCLES (`EXT_WDT_PERIOD_NS / `EXT_CLK_PERIOD_NS)
`define EXT_STARTUP_CYCLES 1024

`endif

// *** ext_pin_irq_pkg.sv ***
`default_nettype none

package ext_pin_irq_pkg;

    typedef enum logic [1:0] {
        SENSE_LOW = 2'h0,
        SENSE_ANY = 2'h1,
        SENSE_FALL = 2'h2,
        SENSE_RISE = 2'h3
    } sense_t;

    typedef enum logic [2:0] {
        WK_RUN = 3'h1,
        WK_SAMPLE = 3'h2,
        WK_START = 3'h4
    } wake_t;

endpackage

`default_nettype wire

// *** hi_group_det.sv ***
`default_nettype none

module hi_group_det
    import ext_pin_irq_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // sampling enable from the i/o clock gate
    input wire logic sample_en,
    // pins and sense fields
    input wire logic [3:0] pin_i,
    input wire logic [7:0] sense_i,
    // detected events
    output logic [3:0] hit_o
);
    logic [3:0] cur_q;
    logic [3:0] prev_q;

    // two samples are compared; a stopped i/o clock freezes both
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cur_q <= 4'h0;
            prev_q <= 4'h0;
        end else if (sample_en) begin
            cur_q <= pin_i;
            prev_q <= cur_q;
        end
    end

    always_comb begin
        for (int n = 0; n < 4; n++) begin
            unique case (sense_t'(sense_i[2*n +: 2]))
                SENSE_ANY: hit_o[n] = sample_en & (prev_q[n] ^ cur_q[n]);
                SENSE_FALL: hit_o[n] = sample_en & prev_q[n] & ~cur_q[n];
                SENSE_RISE: hit_o[n] = sample_en & ~prev_q[n] & cur_q[n];
                SENSE_LOW: hit_o[n] = 1'b0;
            endcase
        end
    end

endmodule

`default_nettype wire

// *** lo_group_det.sv ***
`default_nettype none

module lo_group_det
    import ext_pin_irq_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // pins and sense fields
    input wire logic [3:0] pin_i,
    input wire logic [7:0] sense_i,
    // detected events
    output logic [3:0] hit_o
);
    // this group keeps running on the always-on clock, so sleep does not stop it
    logic [3:0] prev_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prev_q <= 4'h0;
        end else begin
            prev_q <= pin_i;
        end
    end

    always_comb begin
        for (int n = 0; n < 4; n++) begin
            unique case (sense_t'(sense_i[2*n +: 2]))
                SENSE_FALL: hit_o[n] = prev_q[n] & ~pin_i[n];
                SENSE_RISE: hit_o[n] = ~prev_q[n] & pin_i[n];
                SENSE_ANY: hit_o[n] = 1'b0;
                SENSE_LOW: hit_o[n] = 1'b0;
            endcase
        end
    end

endmodule

`default_nettype wire

// *** pin_src.sv ***
`default_nettype none

// ----------------------------------------
// external sources on the interrupt pads
// ----------------------------------------
module pin_src (
    // clock
    input wire logic clk,
    // pad levels
    output logic [7:0] pins
);
    timeunit 1ns;
    timeprecision 1ns;

    // pads idle high as with pull-ups, so reset never sees a low level
    initial pins = 8'hFF;

    task automatic set(input int n, input logic v);
        @(posedge clk);
        pins[n] <= v;
    endtask

    // a low level is held for a whole stretch, never shorter than asked
    task automatic hold_low(input int n, input int cycles);
        set(n, 1'b0);
        repeat (cycles) @(posedge clk);
        set(n, 1'b1);
    endtask
endmodule

`default_nettype wire

// *** tb_top.sv ***
`include "ext_pin_irq_cfg.svh"
`default_nettype none

module tb_top
    import ext_pin_irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, resetn, wr, rd, gie, ack_valid, io_run, sleep, pdown;
    logic [1:0] addr;
    logic [7:0] wdata;
    logic [7:0] d;
    logic [7:0] e;
    logic [2:0] ack_num;
    wire logic [7:0] rdata;
    wire logic [7:0] irq_req;
    wire logic [7:0] pins;
    wire logic irq;
    wire logic wake;
    int fails = 0;
    int samples_checked = 0;
    int cyc = 0;

    pin_src src_u (.clk(clk), .pins(pins));

    ext_pin_irq dut_u (
        .CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .EXT_IRQ_PINS(pins), .GIE(gie), .ACK_VALID(ack_valid),
        .ACK_NUM(ack_num), .IRQ_REQ(irq_req), .IRQ(irq), .IO_CLK_RUN(io_run),
        .SLEEP(sleep), .POWER_DOWN(pdown), .WAKE(wake)
    );

    // ----------------------------------------
    // clock, timeout, report
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic end_sim();
        if (fails == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // whole run is about 1900 cycles; a hang is cut well beyond that
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            fails++;
            end_sim();
        end
    end

    // ----------------------------------------
    // register port tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
        chk(d, exp);
        // hand back on an edge so the caller's next drive lands on the clock
        @(posedge clk);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // mask off, change sense, clear flags, then unmask
    task automatic sense(input logic [1:0] a, input logic [7:0] v, input logic [7:0] m);
        wr_reg(`EXT_ADDR_MASK, 8'h00);
        wr_reg(a, v);
        wr_reg(`EXT_ADDR_FLAGS, 8'hFF);
        wr_reg(`EXT_ADDR_MASK, m);
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        {resetn, wr, rd, gie, ack_valid, io_run, sleep, pdown} = 8'h00;
        addr = 2'h0;
        wdata = 8'h00;
        ack_num = 3'h0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        idle(1);
        rd_chk(`EXT_ADDR_LOW_SENSE, 8'h00);
        rd_chk(`EXT_ADDR_HIGH_SENSE, 8'h00);
        rd_chk(`EXT_ADDR_MASK, 8'h00);
        rd_chk(`EXT_ADDR_FLAGS, 8'h00);
        wr_reg(`EXT_ADDR_MASK, 8'hA5);
        rd_chk(`EXT_ADDR_MASK, 8'hA5);
        // level request follows the pad and the global enable
        gie <= 1'b1;
        wr_reg(`EXT_ADDR_MASK, 8'h01);
        src_u.set(0, 1'b0);
        idle(20);
        chk(irq_req, 8'h01);
        chk({7'h0, irq}, 8'h01);
        rd_chk(`EXT_ADDR_FLAGS, 8'h00);
        gie <= 1'b0;
        idle(3);
        chk(irq_req, 8'h00);
        chk({7'h0, irq}, 8'h00);
        gie <= 1'b1;
        src_u.set(0, 1'b1);
        idle(3);
        chk(irq_req, 8'h00);
        // low group: reserved, falling, rising on pin 1
        for (int k = 1; k < 4; k++) begin
            sense(`EXT_ADDR_LOW_SENSE, 8'(k << 2), 8'h02);
            src_u.set(1, 1'b0);
            idle(4);
            rd_chk(`EXT_ADDR_FLAGS, (k == 2) ? 8'h02 : 8'h00);
            wr_reg(`EXT_ADDR_FLAGS, 8'h02);
            src_u.set(1, 1'b1);
            idle(4);
            e = (k == 3) ? 8'h02 : 8'h00;
            rd_chk(`EXT_ADDR_FLAGS, e);
            chk(irq_req, e);
            ack_valid <= 1'b1;
            ack_num <= 3'h1;
            idle(1);
            ack_valid <= 1'b0;
            idle(2);
            rd_chk(`EXT_ADDR_FLAGS, 8'h00);
        end
        // high group: any change, falling, rising on pin 5
        io_run <= 1'b1;
        for (int k = 1; k < 4; k++) begin
            sense(`EXT_ADDR_HIGH_SENSE, 8'(k << 2), 8'h20);
            src_u.set(5, 1'b0);
            idle(5);
            rd_chk(`EXT_ADDR_FLAGS, (k < 3) ? 8'h20 : 8'h00);
            wr_reg(`EXT_ADDR_FLAGS, 8'h20);
            src_u.set(5, 1'b1);
            idle(5);
            rd_chk(`EXT_ADDR_FLAGS, (k != 2) ? 8'h20 : 8'h00);
            wr_reg(`EXT_ADDR_FLAGS, 8'h20);
            rd_chk(`EXT_ADDR_FLAGS, 8'h00);
        end
        // stopped i/o clock: high group blind, low group edge still seen
        io_run <= 1'b0;
        sense(`EXT_ADDR_HIGH_SENSE, 8'h04, 8'h20);
        sense(`EXT_ADDR_LOW_SENSE, 8'h08, 8'h00);
        src_u.set(5, 1'b0);
        src_u.set(1, 1'b0);
        idle(5);
        rd_chk(`EXT_ADDR_FLAGS, 8'h02);
        chk(irq_req, 8'h00);
        src_u.set(5, 1'b1);
        src_u.set(1, 1'b1);
        io_run <= 1'b1;
        // sleeping with a masked low-group pin turns its buffer off
        sense(`EXT_ADDR_LOW_SENSE, 8'h20, 8'h00);
        sleep <= 1'b1;
        idle(4);
        rd_chk(`EXT_ADDR_FLAGS, 8'h04);
        sleep <= 1'b0;
        // power-down wake on a level; one watchdog tick is not enough
        sense(`EXT_ADDR_LOW_SENSE, 8'h00, 8'h01);
        pdown <= 1'b1;
        src_u.hold_low(0, 30);
        idle(150);
        chk({7'h0, wake}, 8'h00);
        src_u.set(0, 1'b0);
        idle(250);
        chk({7'h0, wake}, 8'h01);
        chk(irq_req, 8'h00);
        src_u.set(0, 1'b1);
        idle(`EXT_STARTUP_CYCLES + 80);
        pdown <= 1'b0;
        idle(3);
        chk(irq_req, 8'h00);
        chk({7'h0, wake}, 8'h00);
        chk({7'h0, irq}, 8'h00);
        end_sim();
    end
endmodule

`default_nettype wire
